// ==== rtl/lic_defines.vh ====
// constants for the local interrupt controller access-mode block
`ifndef LIC_DEFINES_VH
`define LIC_DEFINES_VH
`define LIC_PAGE_BYTES 13'h1000
`define LIC_PAGE_AW 12
`define LIC_ID_W 32
`define LIC_LEG_ID_W 8
`define LIC_HALF_W 16
`define LIC_REG_W 32
`define LIC_NREG 64
`define LIC_REG_IDX_LO 4
`define LIC_REG_IDX_W 6
`define LIC_MSR_BASE 12'h800
`define LIC_IDX_ID 6'h02
`define LIC_IDX_VER 6'h03
`define LIC_IDX_TPR 6'h08
`define LIC_IDX_LDR 6'h0D
`define LIC_IDX_DFR 6'h0E
`define LIC_IDX_SVR 6'h0F
`define LIC_IDX_CMD_LO 6'h30
`define LIC_IDX_CMD_HI 6'h31
`define LIC_IDX_DONE 6'h0B
`define LIC_VER_RST 32'h00050014
`define LIC_DFR_RST 32'hFFFFFFFF
`define LIC_SVR_RST 32'h000000FF
`define LIC_LEG_ID_LSB 24
`endif

// ==== rtl/lic_dest_match.v ====
// destination identifier match for physical and logical modes
`timescale 1ns/1ps
module lic_dest_match #(
	parameter CLUSTER_W = 16,
	parameter MEMBER_W = 16
) (
	input wire ext_mode,
	input wire logical,
	input wire [31:0] dest,
	input wire [31:0] phys_id,
	input wire [31:0] log_id,
	input wire [7:0] leg_dfr_model,
	output reg hit
);
	wire [15:0] cmask;
	wire [15:0] mmask;
	assign cmask = (16'hFFFF >> (16 - CLUSTER_W));
	assign mmask = (16'hFFFF >> (16 - MEMBER_W));
	always @* begin
		hit = 1'b0;
		if (ext_mode) begin
			if (!logical) begin
				// all ones is broadcast in the wide id space
				hit = (dest == 32'hFFFFFFFF) || (dest == phys_id);
			end else begin
				// unimplemented sub-field bits are masked off
				hit = ((dest[31:16] & cmask) == (log_id[31:16] & cmask))
					&& (((dest[15:0] & log_id[15:0]) & mmask) != 16'h0000);
			end
		end else begin
			if (!logical) begin
				hit = (dest[7:0] == 8'hFF) || (dest[7:0] == phys_id[7:0]);
			end else if (leg_dfr_model[7:4] == 4'hF) begin
				hit = (dest[7:0] & log_id[31:24]) != 8'h00;
			end else begin
				hit = (dest[7:4] == log_id[31:28])
					&& ((dest[3:0] & log_id[27:24]) != 4'h0);
			end
		end
	end
endmodule

// ==== rtl/lic_access_mode.v ====
// local interrupt controller register access-mode and id handling
`timescale 1ns/1ps
`include "lic_defines.vh"
module lic_access_mode #(
	parameter [31:0] PHYS_ID = 32'h00000001,
	parameter CLUSTER_W = 16,
	parameter MEMBER_W = 16
) (
	input wire sys_clk,
	input wire rst,
	input wire mode_ext_set,
	input wire mode_disable,
	input wire mm_req,
	input wire mm_we,
	input wire [11:0] mm_addr,
	input wire [31:0] mm_wdata,
	input wire msr_req,
	input wire msr_we,
	input wire [11:0] msr_addr,
	input wire [31:0] msr_wdata,
	input wire [31:0] msr_wdata_hi,
	input wire irq_req,
	input wire irq_logical,
	input wire [31:0] irq_dest,
	output reg mm_ack_ff,
	output reg [31:0] mm_rdata_ff,
	output reg msr_ack_ff,
	output reg msr_fault_ff,
	output reg [31:0] msr_rdata_ff,
	output reg ext_mode_ff,
	output reg irq_hit_ff,
	output reg cmd_send_ff,
	output reg [31:0] cmd_dest_ff,
	output reg [7:0] cmd_vector_ff,
	output reg done_pulse_ff
);
	////////////////////////////////////////////////////////////////
	reg enabled_ff;
	reg [31:0] tpr_ff;
	reg [31:0] ldr_ff;
	reg [31:0] dfr_ff;
	reg [31:0] svr_ff;
	reg [31:0] cmd_lo_ff;
	reg [31:0] cmd_hi_ff;
	wire hit;
	wire [31:0] log_id;
	wire [31:0] ext_ldr;
	wire mm_valid;
	wire msr_in_range;
	wire [5:0] mm_idx;
	wire [5:0] msr_idx;
	wire [11:0] msr_base;

	function [31:0] rd_reg;
		input [5:0] idx;
		input ext;
		begin
			case (idx)
			`LIC_IDX_ID: rd_reg = ext ? PHYS_ID : {PHYS_ID[7:0], 24'h000000};
			`LIC_IDX_VER: rd_reg = `LIC_VER_RST;
			`LIC_IDX_TPR: rd_reg = tpr_ff;
			`LIC_IDX_LDR: rd_reg = ext ? ext_ldr : ldr_ff;
			`LIC_IDX_DFR: rd_reg = ext ? 32'h00000000 : dfr_ff;
			`LIC_IDX_SVR: rd_reg = svr_ff;
			`LIC_IDX_CMD_LO: rd_reg = cmd_lo_ff;
			`LIC_IDX_CMD_HI: rd_reg = cmd_hi_ff;
			default: rd_reg = 32'h00000000;
			endcase
		end
	endfunction

	// cluster in the upper half, one member bit per low id nibble
	function [31:0] ext_ldr_of;
		input [31:0] id;
		begin
			ext_ldr_of = {id[19:4], 16'h0000}
				| ({28'h0000000, 4'h1} << id[3:0]);
		end
	endfunction

	// only the priority byte is writable
	function [31:0] fmt_tpr;
		input [31:0] d;
		begin
			fmt_tpr = {24'h000000, d[7:0]};
		end
	endfunction

	// vector and software-enable bit
	function [31:0] fmt_svr;
		input [31:0] d;
		begin
			fmt_svr = {23'h000000, d[8:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// extended logical id is derived, read-only: cluster from id
	assign ext_ldr = ext_ldr_of(PHYS_ID);
	assign log_id = ext_mode_ff ? ext_ldr : ldr_ff;
	// only 64 slots decode, so they repeat every 1 KByte of the page
	assign mm_idx = mm_addr[9:4];
	assign msr_idx = msr_addr[5:0];
	// memory window is dead once extended mode is on
	assign mm_valid = mm_req && !ext_mode_ff;
	assign msr_base = `LIC_MSR_BASE;
	assign msr_in_range = (msr_addr[11:6] == msr_base[11:6]);

	lic_dest_match #(
		.CLUSTER_W(CLUSTER_W),
		.MEMBER_W(MEMBER_W)
	) u_match (
		.ext_mode(ext_mode_ff),
		.logical(irq_logical),
		.dest(irq_dest),
		.phys_id(PHYS_ID),
		.log_id(log_id),
		.leg_dfr_model(dfr_ff[31:24]),
		.hit(hit)
	);

	////////////////////////////////////////////////////////////////
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_mode_ff <= 1'b0;
			enabled_ff <= 1'b1;
			mm_ack_ff <= 1'b0;
			mm_rdata_ff <= 32'h00000000;
			msr_ack_ff <= 1'b0;
			msr_fault_ff <= 1'b0;
			msr_rdata_ff <= 32'h00000000;
			irq_hit_ff <= 1'b0;
			cmd_send_ff <= 1'b0;
			cmd_dest_ff <= 32'h00000000;
			cmd_vector_ff <= 8'h00;
			done_pulse_ff <= 1'b0;
			tpr_ff <= 32'h00000000;
			ldr_ff <= 32'h00000000;
			dfr_ff <= `LIC_DFR_RST;
			svr_ff <= `LIC_SVR_RST;
			cmd_lo_ff <= 32'h00000000;
			cmd_hi_ff <= 32'h00000000;
		end else begin
			mm_ack_ff <= mm_valid;
			msr_ack_ff <= msr_req;
			msr_fault_ff <= 1'b0;
			cmd_send_ff <= 1'b0;
			done_pulse_ff <= 1'b0;
			irq_hit_ff <= irq_req && enabled_ff && hit;
			// leaving extended mode only through full disable
			if (mode_disable) begin
				ext_mode_ff <= 1'b0;
				enabled_ff <= 1'b0;
			end else if (mode_ext_set) begin
				ext_mode_ff <= 1'b1;
				enabled_ff <= 1'b1;
			end

			if (mm_valid) begin
				mm_rdata_ff <= mm_we ? 32'h00000000 :
					rd_reg(mm_idx, 1'b0);
				if (mm_we) begin
					case (mm_idx)
					`LIC_IDX_TPR: tpr_ff <= fmt_tpr(mm_wdata);
					`LIC_IDX_LDR: ldr_ff <= {mm_wdata[31:24], 24'h000000};
					`LIC_IDX_DFR: dfr_ff <= {mm_wdata[31:28], 28'hFFFFFFF};
					`LIC_IDX_SVR: svr_ff <= fmt_svr(mm_wdata);
					`LIC_IDX_DONE: done_pulse_ff <= 1'b1;
					`LIC_IDX_CMD_HI: cmd_hi_ff <= {mm_wdata[31:24],
						24'h000000};
					`LIC_IDX_CMD_LO: begin
						// legacy send fires on the low half
						cmd_lo_ff <= mm_wdata;
						cmd_send_ff <= 1'b1;
						cmd_vector_ff <= mm_wdata[7:0];
						cmd_dest_ff <= {24'h000000, cmd_hi_ff[31:24]};
					end
					default: ;
					endcase
				end
			end else begin
				mm_rdata_ff <= 32'h00000000;
			end

			if (msr_req) begin
				// msr path only exists in extended mode
				if (!ext_mode_ff || !msr_in_range) begin
					msr_fault_ff <= 1'b1;
					msr_rdata_ff <= 32'h00000000;
				end else begin
					msr_rdata_ff <= msr_we ? 32'h00000000 :
						rd_reg(msr_idx, 1'b1);
					if (msr_we) begin
						case (msr_idx)
						`LIC_IDX_TPR: tpr_ff <= fmt_tpr(msr_wdata);
						`LIC_IDX_SVR: svr_ff <= fmt_svr(msr_wdata);
						`LIC_IDX_DONE: done_pulse_ff <= 1'b1;
						`LIC_IDX_CMD_LO: begin
							// one 64-bit write sends, no split halves
							cmd_lo_ff <= msr_wdata;
							cmd_hi_ff <= msr_wdata_hi;
							cmd_send_ff <= 1'b1;
							cmd_vector_ff <= msr_wdata[7:0];
							cmd_dest_ff <= msr_wdata_hi;
						end
						default: msr_fault_ff <= 1'b1;
						endcase
					end
				end
			end else begin
				msr_rdata_ff <= 32'h00000000;
			end
		end
	end
endmodule

// ==== testbench/lic_access_mode_asserts.sv ====
// port assertions for the access-mode block
`timescale 1ns/1ps
module lic_access_mode_asserts #(
	parameter [31:0] PHYS_ID = 32'h00000001
) (
	input wire sys_clk,
	input wire rst,
	input wire mode_ext_set,
	input wire mode_disable,
	input wire mm_req,
	input wire msr_req,
	input wire msr_we,
	input wire [11:0] msr_addr,
	input wire mm_ack_ff,
	input wire msr_ack_ff,
	input wire msr_fault_ff,
	input wire [31:0] msr_rdata_ff,
	input wire ext_mode_ff
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_id_rd;
		msr_req && !msr_we && msr_addr == 12'h802 && ext_mode_ff;
	endsequence
	sequence s_id_ans;
		msr_rdata_ff == PHYS_ID && !msr_fault_ff;
	endsequence
	a_mm_legacy_ack: assert property (mm_req && !ext_mode_ff |=> mm_ack_ff)
		else $error("window access not acked");
	a_mm_no_req: assert property (!mm_req |=> !mm_ack_ff)
		else $error("window ack without request");
	a_mm_ext_ignored: assert property (mm_req && ext_mode_ff |=> !mm_ack_ff)
		else $error("window acked in extended mode");
	a_msr_ack: assert property (msr_req |=> msr_ack_ff)
		else $error("msr access not acked");
	a_msr_refused: assert property (msr_req && !ext_mode_ff |=> msr_fault_ff)
		else $error("msr access in legacy mode not refused");
	a_ext_enter: assert property (mode_ext_set && !mode_disable |=> ext_mode_ff)
		else $error("extended mode not entered");
	a_ext_leave: assert property (mode_disable |=> !ext_mode_ff)
		else $error("extended mode not left");
	a_phys_id: assert property (s_id_rd |=> s_id_ans)
		else $error("wide id read wrong");
endmodule
bind lic_access_mode lic_access_mode_asserts #(.PHYS_ID(PHYS_ID))
	lic_access_mode_asserts_i (.*);

// ==== testbench/test_lic_access_mode.sv ====
// bench for the access-mode block
`timescale 1ns/1ps
`include "lic_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH %0t %h %h", $time, a, b); end end
module test_lic_access_mode;
	// id wider than 8 bits so truncation shows
	localparam [31:0] ID = 32'h00012345;
	reg sys_clk = 0, rst = 1, mode_ext_set = 0, mode_disable = 0;
	reg mm_req = 0, mm_we = 0, msr_req = 0, msr_we = 0;
	reg irq_req = 0, irq_logical = 0;
	reg [11:0] mm_addr = 0, msr_addr = 0;
	reg [31:0] mm_wdata = 0, msr_wdata = 0, msr_wdata_hi = 0, irq_dest = 0;
	wire mm_ack_ff, msr_ack_ff, msr_fault_ff, ext_mode_ff, irq_hit_ff;
	wire cmd_send_ff, done_pulse_ff;
	wire [7:0] cmd_vector_ff;
	wire [31:0] mm_rdata_ff, msr_rdata_ff, cmd_dest_ff;
	int mismatches = 0, n_tests = 0;
	lic_access_mode #(.PHYS_ID(ID)) lic_access_mode_i (
		.sys_clk(sys_clk), .rst(rst),
		.mode_ext_set(mode_ext_set), .mode_disable(mode_disable),
		.mm_req(mm_req), .mm_we(mm_we), .mm_addr(mm_addr),
		.mm_wdata(mm_wdata),
		.msr_req(msr_req), .msr_we(msr_we), .msr_addr(msr_addr),
		.msr_wdata(msr_wdata), .msr_wdata_hi(msr_wdata_hi),
		.irq_req(irq_req), .irq_logical(irq_logical),
		.irq_dest(irq_dest),
		.mm_ack_ff(mm_ack_ff), .mm_rdata_ff(mm_rdata_ff),
		.msr_ack_ff(msr_ack_ff), .msr_fault_ff(msr_fault_ff),
		.msr_rdata_ff(msr_rdata_ff), .ext_mode_ff(ext_mode_ff),
		.irq_hit_ff(irq_hit_ff), .cmd_send_ff(cmd_send_ff),
		.cmd_dest_ff(cmd_dest_ff), .cmd_vector_ff(cmd_vector_ff),
		.done_pulse_ff(done_pulse_ff)
	);
	always #2 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	// one access; answer is sampled at the following falling edge
	task acc(input m, input w, input [11:0] a, input [31:0] d);
		@(negedge sys_clk);
		{mm_req, msr_req, mm_we, msr_we} = {m, !m, w, w};
		mm_addr = a;
		msr_addr = a;
		mm_wdata = d;
		msr_wdata = d;
		@(negedge sys_clk);
		{mm_req, msr_req} = 2'h0;
	endtask
	// one interrupt address; the hit pulse stands at the return
	task irq(input l, input [31:0] d);
		@(negedge sys_clk);
		{irq_req, irq_logical, irq_dest} = {1'h1, l, d};
		@(negedge sys_clk);
		irq_req = 0;
	endtask
	task tally_and_finish;
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#4000;
		mismatches++;
		tally_and_finish;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk) rst = 0;
		acc(1, 0, 12'h020, 0);
		`CHK({mm_ack_ff, mm_rdata_ff}, {1'h1, ID[7:0], 24'h0})
		acc(1, 0, 12'h030, 0);
		`CHK(mm_rdata_ff, `LIC_VER_RST)
		acc(0, 0, 12'h802, 0);
		`CHK({msr_ack_ff, msr_fault_ff}, 2'h3)
		acc(1, 1, 12'h0D0, 32'h03000000);
		acc(1, 0, 12'h0D0, 0);
		`CHK(mm_rdata_ff, 32'h03000000)
		irq(1, 32'h00000002);
		`CHK(irq_hit_ff, 1'h1)
		irq(1, 32'h00000004);
		`CHK(irq_hit_ff, 1'h0)
		irq(0, 32'h00000045);
		`CHK(irq_hit_ff, 1'h1)
		acc(1, 1, 12'h0E0, 32'h0FFFFFFF);
		irq(1, 32'h00000001);
		`CHK(irq_hit_ff, 1'h1)
		irq(1, 32'h00000011);
		`CHK(irq_hit_ff, 1'h0)
		acc(1, 1, 12'h310, 32'h07000000);
		acc(1, 1, 12'h300, 32'h00000041);
		`CHK({cmd_send_ff, cmd_vector_ff}, 9'h141)
		`CHK(cmd_dest_ff, 32'h00000007)
		acc(1, 1, 12'h0B0, 0);
		`CHK(done_pulse_ff, 1'h1)
		@(negedge sys_clk) mode_ext_set = 1;
		@(negedge sys_clk) mode_ext_set = 0;
		`CHK(ext_mode_ff, 1'h1)
		acc(1, 0, 12'h020, 0);
		`CHK(mm_ack_ff, 1'h0)
		acc(0, 0, 12'h802, 0);
		`CHK({msr_ack_ff, msr_fault_ff, msr_rdata_ff}, {2'h2, ID})
		acc(0, 0, 12'h80D, 0);
		`CHK(msr_rdata_ff, 32'h12340020)
		acc(0, 1, 12'h808, 32'h5A);
		acc(0, 0, 12'h808, 0);
		`CHK(msr_rdata_ff, 32'h5A)
		acc(1, 1, 12'h080, 32'h77);
		acc(0, 0, 12'h808, 0);
		`CHK(msr_rdata_ff, 32'h5A)
		acc(0, 0, 12'h8F0, 0);
		`CHK({msr_ack_ff, msr_fault_ff}, 2'h3)
		@(negedge sys_clk) {irq_req, irq_logical, irq_dest} = {2'h2, ID};
		@(negedge sys_clk) irq_dest = ID ^ 32'h100;
		`CHK(irq_hit_ff, 1'h1)
		@(negedge sys_clk) irq_req = 0;
		`CHK(irq_hit_ff, 1'h0)
		irq(1, 32'h12340021);
		`CHK(irq_hit_ff, 1'h1)
		irq(1, 32'h12350020);
		`CHK(irq_hit_ff, 1'h0)
		irq(1, 32'h12340010);
		`CHK(irq_hit_ff, 1'h0)
		msr_wdata_hi = 32'h00ABCDEF;
		acc(0, 1, 12'h830, 32'h00000062);
		`CHK({cmd_send_ff, cmd_vector_ff}, 9'h162)
		`CHK(cmd_dest_ff, 32'h00ABCDEF)
		acc(0, 1, 12'h80B, 0);
		`CHK(done_pulse_ff, 1'h1)
		@(negedge sys_clk) mode_disable = 1;
		@(negedge sys_clk) mode_disable = 0;
		`CHK(ext_mode_ff, 1'h0)
		acc(1, 0, 12'h0F0, 0);
		`CHK({mm_ack_ff, mm_rdata_ff}, {1'h1, `LIC_SVR_RST})
		tally_and_finish;
	end
endmodule
